// ### design/idp_map.svh
/*
 * Register offsets, field positions and reset values of the internal
 * decoder I/O port. Assumes inclusion by bare name from design files.
 */
`ifndef IDP_MAP_SVH
`define IDP_MAP_SVH

`define IDP_ADDR_FUNC_SEL     16'hffc9
`define IDP_ADDR_DRV_TYPE     16'hffcb
`define IDP_ADDR_PIN_DATA     16'hffd5
`define IDP_ADDR_PIN_DIR      16'hffe5

`define IDP_RST_FUNC_SEL      8'hd8
`define IDP_RST_DRV_TYPE      8'h00
`define IDP_RST_PIN_DATA      8'h00
`define IDP_RST_PIN_DIR       8'h00

`define IDP_FUNC_FIXED_ONES   8'hd8
`define IDP_FUNC_WR_MASK      8'h27
`define IDP_DIR_READ_VALUE    8'hff
`define IDP_UNMAPPED_READ     8'h00

`define IDP_BIT_SCK_EN        0
`define IDP_BIT_SI_EN         1
`define IDP_BIT_SO_EN         2
`define IDP_BIT_SO_DRV        5

`define IDP_PIN_SCK           0
`define IDP_PIN_SI            1
`define IDP_PIN_SO            2

`define IDP_RST_PIN_LEVEL     5'h08
`define IDP_RST_PIN_OE        5'h1f

`endif

// ### design/idp_pkg.sv
/*
 * Types shared by the internal decoder I/O port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package idp_pkg;
    localparam int IDP_PINS = 5;
    typedef logic [IDP_PINS-1:0] idp_pins_t;
    typedef logic [7:0]          idp_byte_t;
    typedef logic [15:0]         idp_addr_t;
endpackage

// ### design/idp_pin_if.sv
/*
 * Carrier of per-pin control from the register side to the pin mux.
 * Assumes the top drives ctrl and reads the mux answers.
 */
`timescale 1ns/1ps
interface idp_pin_if;
    import idp_pkg::*;
    idp_pins_t data;
    idp_pins_t dir;
    idp_pins_t od_sel;
    logic      so_od;
    logic      so_en;
    logic      si_en;
    logic      sck_en;
    logic      ser_out;
    logic      ser_clk_out;
    logic      ser_clk_oe;
    idp_pins_t next_level;
    idp_pins_t next_oe;

    modport ctrl (output data, dir, od_sel, so_od, so_en, si_en, sck_en,
                  output ser_out, ser_clk_out, ser_clk_oe,
                  input  next_level, next_oe);
    modport mux  (input  data, dir, od_sel, so_od, so_en, si_en, sck_en,
                  input  ser_out, ser_clk_out, ser_clk_oe,
                  output next_level, next_oe);
endinterface

// ### design/idp_sync.sv
/*
 * Two-flop synchroniser, one per pin.
 * Assumes async inputs from the decoder block; mclk domain.
 */
`timescale 1ns/1ps
module idp_sync
    import idp_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rstn,
    input  wire idp_pins_t async_in,
    output idp_pins_t      sync_out
);
    idp_pins_t stage1;

    genvar i;
    generate
        for (i = 0; i < IDP_PINS; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// ### design/idp_pin_mux.sv
/*
 * Per-pin function and driver selection, purely combinational.
 * Assumes the top registers the answers before they leave the block.
 */
`timescale 1ns/1ps
`include "idp_map.svh"
module idp_pin_mux
    import idp_pkg::*;
(
    idp_pin_if.mux p
);
    genvar i;
    generate
        for (i = 0; i < IDP_PINS; i++) begin : g_pin
            logic ser_sel;
            logic ser_drive;
            logic ser_lvl;
            logic drive;
            logic lvl;
            logic od;
            always_comb begin
                ser_sel   = 1'b0;
                ser_drive = 1'b0;
                ser_lvl   = 1'b0;
                od        = p.od_sel[i];
                if (i == `IDP_PIN_SO) begin
                    ser_sel   = p.so_en;
                    ser_drive = 1'b1;
                    ser_lvl   = p.ser_out;
                    if (p.so_en) begin
                        od = p.so_od;
                    end
                end else if (i == `IDP_PIN_SI) begin
                    ser_sel = p.si_en;
                end else if (i == `IDP_PIN_SCK) begin
                    ser_sel   = p.sck_en;
                    ser_drive = p.ser_clk_oe;
                    ser_lvl   = p.ser_clk_out;
                end
                // Serial function overrides direction and data
                drive = ser_sel ? ser_drive : p.dir[i];
                lvl   = ser_sel ? ser_lvl : p.data[i];
                // Open drain only ever pulls low; released high is the far side's pull-up
                p.next_level[i] = lvl;
                p.next_oe[i]    = drive & ~(od & lvl);
            end
        end
    endgenerate
endmodule

// ### design/idp_port.sv
/*
 * Internal five-pin I/O port between the CPU registers and the on-chip
 * decoder block, with a serial channel sharing pins 2..0.
 * Assumes a single-cycle register port and decoder logic at the pins only.
 */
// Local design decision: the address-and-strobe port.
// How it works
// - Five two-way pins 4..0, held in bits 4..0 of the data, direction and driver select registers.
// - Pins reach only the on-chip decoder, never a package pin.
// - Data register holds pin output values and resets to zero.
// - With direction 1, data read returns the stored value, not the pin.
// - Direction bit 1 drives pin from data register; 0 makes it input.
// - Direction and data act only while the pin is general I/O.
// - Direction register is write-only, resets zero, reads all ones.
// - Function select bits 7,6,4,3 read one; register resets to 0xd8.
// - Function bit 5 picks serial-out driver: 0 push-pull, 1 open-drain.
// - Function bit 2 routes pin 2 to serial data out.
// - Function bit 1 routes pin 1 to serial data in.
// - Function bit 0 routes pin 0 to the two-way serial clock.
// - Driver select bits make each pin open-drain when set, except pin 2 as serial out (bit 5 decides); reset zero.
// - Reset drives pin 3 high, others low; low power holds pins.
// - Serial function ignores direction; pins 4 and 3 follow direction only.
`timescale 1ns/1ps
`include "idp_map.svh"
module idp_port
    import idp_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rstn,
    input  wire idp_addr_t reg_addr,
    input  wire idp_byte_t reg_wdata,
    input  wire logic      reg_wr,
    input  wire logic      reg_rd,
    output idp_byte_t      reg_rdata,
    input  wire logic      low_power_hold,
    input  wire idp_pins_t port_pin_in,
    output idp_pins_t      port_pin_out,
    output idp_pins_t      port_pin_oe,
    input  wire logic      ser_data_out,
    input  wire logic      ser_clk_out,
    input  wire logic      ser_clk_oe,
    output logic           ser_data_in,
    output logic           ser_clk_in
);
    idp_pins_t port_pin_data;
    idp_pins_t port_pin_direction;
    idp_byte_t pin_function_select;
    idp_pins_t driver_type_select;
    idp_pins_t pin_level;
    idp_byte_t next_rdata;
    idp_pins_t data_view;

    idp_pin_if pif ();

    // Pins come from decoder logic of unknown timing
    idp_sync u_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in (port_pin_in),
        .sync_out (pin_level)
    );

    idp_pin_mux u_mux (
        .p (pif.mux)
    );

    assign pif.data        = port_pin_data;
    assign pif.dir         = port_pin_direction;
    assign pif.od_sel      = driver_type_select;
    assign pif.so_od       = pin_function_select[`IDP_BIT_SO_DRV];
    assign pif.so_en       = pin_function_select[`IDP_BIT_SO_EN];
    assign pif.si_en       = pin_function_select[`IDP_BIT_SI_EN];
    assign pif.sck_en      = pin_function_select[`IDP_BIT_SCK_EN];
    assign pif.ser_out     = ser_data_out;
    assign pif.ser_clk_out = ser_clk_out;
    assign pif.ser_clk_oe  = ser_clk_oe;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port_pin_data <= idp_pins_t'(`IDP_RST_PIN_DATA);
        end else if (reg_wr && reg_addr == `IDP_ADDR_PIN_DATA) begin
            port_pin_data <= reg_wdata[IDP_PINS-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port_pin_direction <= idp_pins_t'(`IDP_RST_PIN_DIR);
        end else if (reg_wr && reg_addr == `IDP_ADDR_PIN_DIR) begin
            port_pin_direction <= reg_wdata[IDP_PINS-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_function_select <= `IDP_RST_FUNC_SEL;
        end else if (reg_wr && reg_addr == `IDP_ADDR_FUNC_SEL) begin
            // Reserved bits stay one whatever is written
            pin_function_select <= (reg_wdata & `IDP_FUNC_WR_MASK) | `IDP_FUNC_FIXED_ONES;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            driver_type_select <= idp_pins_t'(`IDP_RST_DRV_TYPE);
        end else if (reg_wr && reg_addr == `IDP_ADDR_DRV_TYPE) begin
            driver_type_select <= reg_wdata[IDP_PINS-1:0];
        end
    end

    // Input pins read the synchronised level; software should not rely on it
    always_comb begin
        for (int i = 0; i < IDP_PINS; i++) begin
            data_view[i] = port_pin_direction[i] ? port_pin_data[i] : pin_level[i];
        end
    end

    always_comb begin
        case (reg_addr)
            `IDP_ADDR_PIN_DATA: next_rdata = {3'h0, data_view};
            `IDP_ADDR_PIN_DIR:  next_rdata = `IDP_DIR_READ_VALUE;
            `IDP_ADDR_FUNC_SEL: next_rdata = pin_function_select;
            `IDP_ADDR_DRV_TYPE: next_rdata = {3'h0, driver_type_select};
            default:            next_rdata = `IDP_UNMAPPED_READ;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Pins freeze in low-power modes so the decoder sees no glitch
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port_pin_out <= `IDP_RST_PIN_LEVEL;
            port_pin_oe  <= `IDP_RST_PIN_OE;
        end else if (!low_power_hold) begin
            port_pin_out <= pif.next_level;
            port_pin_oe  <= pif.next_oe;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ser_data_in <= 1'b0;
            ser_clk_in  <= 1'b0;
        end else if (!low_power_hold) begin
            ser_data_in <= pif.si_en ? pin_level[`IDP_PIN_SI] : 1'b0;
            ser_clk_in  <= pif.sck_en ? pin_level[`IDP_PIN_SCK] : 1'b0;
        end
    end
endmodule

// ### sim/idp_port_properties.sv
/* Checker of register reads and pin drive for the port.
   Assumes a bind to idp_port and a single clock domain. */
`timescale 1ns/1ps
`include "idp_map.svh"
module idp_port_properties
    import idp_pkg::*;
(
    input wire logic      mclk,
    input wire logic      rstn,
    input wire idp_addr_t reg_addr,
    input wire idp_byte_t reg_wdata,
    input wire logic      reg_wr,
    input wire logic      reg_rd,
    input wire idp_byte_t reg_rdata,
    input wire logic      low_power_hold,
    input wire idp_pins_t port_pin_out,
    input wire idp_pins_t port_pin_oe,
    input wire logic      ser_data_out,
    input wire logic      ser_clk_out,
    input wire logic      ser_clk_oe
);
    idp_pins_t dat, dir, drv, ex_oe, ex_lv;
    logic [2:0] fs;
    logic       od5;
    logic       mapped;
    assign mapped = reg_addr inside {16'hffc9, 16'hffcb, 16'hffd5, 16'hffe5};
    // Shadow copy of the control registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            {dat, dir, drv, fs, od5} <= 19'h00000;
        end else if (reg_wr) begin
            case (reg_addr)
                `IDP_ADDR_PIN_DATA: dat <= reg_wdata[4:0];
                `IDP_ADDR_PIN_DIR:  dir <= reg_wdata[4:0];
                `IDP_ADDR_DRV_TYPE: drv <= reg_wdata[4:0];
                `IDP_ADDR_FUNC_SEL: {od5, fs} <= {reg_wdata[5], reg_wdata[2:0]};
                default: ;
            endcase
        end
    end
    always_comb begin
        ex_lv = dat;
        ex_oe = dir & ~(drv & dat);
        if (fs[2]) begin
            ex_lv[2] = ser_data_out;
            ex_oe[2] = ~(od5 & ser_data_out);
        end
        if (fs[1]) begin
            ex_oe[1] = 1'b0;
        end
        if (fs[0]) begin
            ex_lv[0] = ser_clk_out;
            // Driver select still applies to the serial clock pin
            ex_oe[0] = ser_clk_oe & ~(drv[0] & ser_clk_out);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_pin_enable;
        $past(rstn) && !$past(low_power_hold) |-> port_pin_oe == $past(ex_oe);
    endproperty
    property p_pin_level;
        $past(rstn) && !$past(low_power_hold) |-> (port_pin_out & port_pin_oe) == ($past(ex_lv) & port_pin_oe);
    endproperty
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_dir_ones: assert property (reg_rd && reg_addr == 16'hffe5 |=> reg_rdata == 8'hff)
        else $error("direction read not all ones");
    a_func_fixed: assert property (reg_rd && reg_addr == 16'hffc9 |=> (reg_rdata & 8'hd8) == 8'hd8)
        else $error("fixed function bits not one");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_pins: assert property ($rose(rstn) |-> port_pin_out == 5'h08 && port_pin_oe == 5'h1f)
        else $error("reset pin state wrong");
    a_pin_enable: assert property (p_pin_enable)
        else $error("pin enable wrong");
    a_pin_level: assert property (p_pin_level)
        else $error("pin level wrong");
    a_hold_freeze: assert property (low_power_hold |=> $stable(port_pin_out) && $stable(port_pin_oe))
        else $error("pins moved in hold");
    c_data_read: cover property (reg_rd && reg_addr == 16'hffd5);
    c_hold: cover property (low_power_hold);
    c_clk_drive: cover property (ser_clk_oe && port_pin_oe[0]);
endmodule
bind idp_port idp_port_properties i_idp_port_properties (.*);

// ### sim/idp_dec_model.sv
/* Decoder-side model of the five internal pins.
   Assumes the bench steers its drive; no pull on any line. */
`timescale 1ns/1ps
module idp_dec_model
    import idp_pkg::*;
(
    input  wire logic      mclk,
    input  wire idp_pins_t port_pin_out,
    input  wire idp_pins_t port_pin_oe,
    input  wire idp_pins_t dec_level,
    input  wire idp_pins_t dec_oe,
    output idp_pins_t      pin_wire
);
    idp_pins_t float_pat = 5'h15;
    // Released line wanders so a stale value never passes
    always @(posedge mclk) float_pat <= ~float_pat;
    // Only the port and this block meet on a pin
    always_comb begin
        for (int n = 0; n < IDP_PINS; n++) begin
            pin_wire[n] = port_pin_oe[n] ? port_pin_out[n] : dec_oe[n] ? dec_level[n] : float_pat[n];
        end
    end
endmodule

// ### sim/internal_decoder_io_port_tb_top.sv
/* Register and pin tests of the internal decoder port.
   Assumes idp_port, the decoder model and the bound checker. */
`timescale 1ns/1ps
module internal_decoder_io_port_tb_top
    import idp_pkg::*;
;
    logic      mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power_hold = 1'b0;
    logic      ser_data_out = 1'b0, ser_clk_out = 1'b0, ser_clk_oe = 1'b0, ser_data_in, ser_clk_in;
    idp_addr_t reg_addr = 16'h0000;
    idp_byte_t reg_wdata = 8'h00, reg_rdata;
    idp_pins_t dec_level = 5'h00, dec_oe = 5'h00, port_pin_out, port_pin_oe, pin_wire;
    int        bad_count = 0, tests_run = 0, cycles = 0;
    always #5 mclk = ~mclk;
    idp_port i_idp_port (
        .mclk           (mclk),
        .rstn           (rstn),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .low_power_hold (low_power_hold),
        .port_pin_in    (pin_wire),
        .port_pin_out   (port_pin_out),
        .port_pin_oe    (port_pin_oe),
        .ser_data_out   (ser_data_out),
        .ser_clk_out    (ser_clk_out),
        .ser_clk_oe     (ser_clk_oe),
        .ser_data_in    (ser_data_in),
        .ser_clk_in     (ser_clk_in)
    );
    idp_dec_model i_idp_dec_model (
        .mclk         (mclk),
        .port_pin_out (port_pin_out),
        .port_pin_oe  (port_pin_oe),
        .dec_level    (dec_level),
        .dec_oe       (dec_oe),
        .pin_wire     (pin_wire)
    );
    task complete_run();
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input idp_byte_t seen, input idp_byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Idle cycle after each strobe keeps one assignment per time step
    task wr(input idp_addr_t a, input idp_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task rd(input idp_addr_t a, input idp_byte_t e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        tick(1);
    endtask
    task pins(input idp_pins_t oe, input idp_pins_t lv);
        #1 chk({3'h0, port_pin_oe}, {3'h0, oe});
        chk({3'h0, port_pin_out & port_pin_oe}, {3'h0, lv & oe});
        tick(1);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        tick(3);
        rstn <= 1'b1;
        pins(5'h1f, 5'h08);
        rd(16'hffc9, 8'hd8);
        rd(16'hffcb, 8'h00);
        rd(16'hffe5, 8'hff);
        rd(16'hffd4, 8'h00);
        wr(16'hffc9, 8'h00);
        rd(16'hffc9, 8'hd8);
        wr(16'hffe5, 8'hff);
        wr(16'hffd5, 8'hff);
        rd(16'hffe5, 8'hff);
        rd(16'hffd5, 8'h1f);
        pins(5'h1f, 5'h1f);
        wr(16'hffe5, 8'h18);
        wr(16'hffd5, 8'h10);
        pins(5'h18, 5'h10);
        {ser_data_out, ser_clk_out, ser_clk_oe} <= 3'h7;
        {dec_oe, dec_level} <= {5'h02, 5'h02};
        wr(16'hffc9, 8'h07);
        tick(3);
        #1 chk({7'h00, ser_data_in}, 8'h01);
        chk({7'h00, ser_clk_in}, 8'h01);
        pins(5'h1d, 5'h15);
        ser_clk_oe <= 1'b0;
        dec_oe <= 5'h03;
        wr(16'hffc9, 8'h27);
        tick(3);
        #1 chk({7'h00, ser_clk_in}, 8'h00);
        pins(5'h18, 5'h10);
        dec_oe <= 5'h00;
        wr(16'hffc9, 8'h00);
        wr(16'hffe5, 8'h1f);
        wr(16'hffd5, 8'h0a);
        wr(16'hffcb, 8'hff);
        rd(16'hffcb, 8'h1f);
        pins(5'h15, 5'h00);
        // Decoder pulls the released pins low, so stored and seen levels differ
        {dec_oe, dec_level} <= {5'h0a, 5'h00};
        tick(2);
        rd(16'hffd5, 8'h0a);
        dec_oe <= 5'h00;
        wr(16'hffcb, 8'h00);
        low_power_hold <= 1'b1;
        wr(16'hffd5, 8'h15);
        pins(5'h1f, 5'h0a);
        low_power_hold <= 1'b0;
        tick(1);
        pins(5'h1f, 5'h15);
        rd(16'hffd5, 8'h15);
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        pins(5'h1f, 5'h08);
        rd(16'hffc9, 8'hd8);
        complete_run();
    end
endmodule
